/* File: verilog/hhdma_engine.sv */
// Four-channel memory transfer engine with core halt handshake
//
// What this block does
// - Four independent channels move bytes within memory or to/from it.
// - Two modem channels have only start and address ports, no size or idle ports.
// - Modem channels take both source and dest addresses; only the packet size is fixed.
// - General channels take source, dest, sizes and idle times.
// - A halt request goes to the core before memory is touched.
// - No memory cycle starts until the core's halted acknowledge is seen.
// - Each channel requests with a one-cycle pulse; several may coincide.
// - Simultaneous requests are granted highest priority first; the others wait for later grants.
// - Halt request stays high from the grant to the end of the access.
// - The access window lasts four cycles per byte moved.
// - The halt request drops when the access window ends.
// - Each byte takes one read cycle and three write cycles.
`timescale 1ns/1ps
module hhdma_engine
   import hhdma_pkg::*;
(
   // Clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        arst_n,
   // Core halt handshake
   output logic                             core_halt_req,
   input  wire logic                        core_halted,
   // Modem channels
   input  wire logic                        modem_rx_start,
   input  wire logic [hhdma_pkg::ADDR_W-1:0] modem_rx_dst,
   input  wire logic [hhdma_pkg::ADDR_W-1:0] modem_rx_src,
   input  wire logic                        modem_tx_start,
   input  wire logic [hhdma_pkg::ADDR_W-1:0] modem_tx_src,
   input  wire logic [hhdma_pkg::ADDR_W-1:0] modem_tx_dst,
   // General channel 1
   input  wire logic                        gen1_start,
   input  wire logic [hhdma_pkg::ADDR_W-1:0] gen1_src,
   input  wire logic [hhdma_pkg::ADDR_W-1:0] gen1_dst,
   input  wire logic [hhdma_pkg::LEN_W-1:0]  gen1_src_size,
   input  wire logic [hhdma_pkg::LEN_W-1:0]  gen1_dst_size,
   input  wire logic [7:0]                  gen1_idle,
   // General channel 2
   input  wire logic                        gen2_start,
   input  wire logic [hhdma_pkg::ADDR_W-1:0] gen2_src,
   input  wire logic [hhdma_pkg::ADDR_W-1:0] gen2_dst,
   input  wire logic [hhdma_pkg::LEN_W-1:0]  gen2_src_size,
   input  wire logic [hhdma_pkg::LEN_W-1:0]  gen2_dst_size,
   input  wire logic [7:0]                  gen2_idle,
   // Memory port
   output logic      [hhdma_pkg::ADDR_W-1:0] mem_addr,
   output logic      [hhdma_pkg::DATA_W-1:0] mem_wdata,
   input  wire logic [hhdma_pkg::DATA_W-1:0] mem_rdata,
   output logic                             mem_oe,
   output logic                             mem_we,
   output logic                             mem_drive,
   // Status
   output logic      [hhdma_pkg::NUM_CH-1:0] ch_busy,
   output logic      [hhdma_pkg::NUM_CH-1:0] ch_done
);
   typedef struct packed
   {
      hhdma_state_t                          state;
      logic [NUM_CH-1:0]                     pend;
      logic [NUM_CH-1:0]                     req;
      logic [NUM_CH-1:0]                     done;
      logic [NUM_CH-1:0][ADDR_W-1:0]         src;
      logic [NUM_CH-1:0][ADDR_W-1:0]         dst;
      logic [NUM_CH-1:0][LEN_W-1:0]          left;
      logic [NUM_CH-1:0][7:0]                idle;
      logic [1:0]                            cur;
      logic [LEN_W-1:0]                      cnt;
      logic [1:0]                            wcyc;
      logic                                  halt;
      logic [ADDR_W-1:0]                     addr;
      logic                                  oe;
      logic                                  we;
   } hhdma_st_t;

   hhdma_st_t              st_reg;
   hhdma_st_t              st_next;
   logic [NUM_CH-1:0]      start_v;
   logic [NUM_CH-1:0][ADDR_W-1:0] src_v;
   logic [NUM_CH-1:0][ADDR_W-1:0] dst_v;
   logic [NUM_CH-1:0][LEN_W-1:0]  len_v;
   logic [NUM_CH-1:0][7:0]        idle_v;
   logic                   fifo_in_ready;
   logic                   fifo_out_valid;
   logic [DATA_W-1:0]      fifo_out_data;
   logic                   fifo_push;
   logic                   fifo_pop;

   always_comb
   begin
      // every channel, modem ones too, takes start, source and dest ports
      start_v = {modem_rx_start, modem_tx_start, gen1_start, gen2_start};
      src_v   = {modem_rx_src, modem_tx_src, gen1_src, gen2_src};
      dst_v   = {modem_rx_dst, modem_tx_dst, gen1_dst, gen2_dst};
      // general sizes: the shorter side bounds the move
      len_v[CH_GEN2] = (gen2_src_size < gen2_dst_size) ? gen2_src_size
                                                       : gen2_dst_size;
      len_v[CH_GEN1] = (gen1_src_size < gen1_dst_size) ? gen1_src_size
                                                       : gen1_dst_size;
      len_v[CH_MODEM_TX] = MODEM_PKT_BYTES;
      len_v[CH_MODEM_RX] = MODEM_PKT_BYTES;
      idle_v  = {IDLE_RST, IDLE_RST, gen1_idle, gen2_idle};
   end

   // Read byte enters the FIFO; the write phase drains it
   assign fifo_push = (st_reg.state == HHDMA_READ) && core_halted &&
                      fifo_in_ready;
   assign fifo_pop  = (st_reg.state == HHDMA_WRITE) && fifo_out_valid &&
                      (st_reg.wcyc == WR_LAST);

   hhdma_fifo
   #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   )
   u_fifo
   (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   (mem_rdata),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   always_comb
   begin
      st_next      = st_reg;
      st_next.req  = '0;
      st_next.done = '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         // Zero-length starts are dropped so busy cannot stick
         if (start_v[i] && !st_reg.pend[i] && (len_v[i] != '0))
         begin
            st_next.pend[i] = 1'b1;
            st_next.src[i]  = src_v[i];
            st_next.dst[i]  = dst_v[i];
            st_next.left[i] = len_v[i];
         end
         // idle gap runs out before the next request
         if (st_reg.idle[i] != '0)
         begin
            st_next.idle[i] = st_reg.idle[i] - 1'b1;
         end
         st_next.req[i] = st_reg.pend[i] && (st_reg.idle[i] == '0) &&
                          (st_reg.state == HHDMA_IDLE) && !st_reg.req[i] &&
                          (st_reg.left[i] != '0);
      end
      st_next.oe = 1'b0;
      st_next.we = 1'b0;
      case (st_reg.state)
         HHDMA_IDLE:
         begin
            for (int i = 0; i < NUM_CH; i++)
            begin
               if (st_reg.req[i])
               begin
                  st_next.cur = 2'(i);
               end
            end
            if (st_reg.req != '0)
            begin
               st_next.req   = '0;
               st_next.halt  = 1'b1;
               st_next.cnt   = st_next.left[st_next.cur];
               st_next.state = HHDMA_WAIT_HALT;
            end
         end
         HHDMA_WAIT_HALT:
         begin
            if (core_halted)
            begin
               st_next.state = HHDMA_READ;
               st_next.addr  = st_reg.src[st_reg.cur];
               st_next.oe    = 1'b1;
            end
         end
         HHDMA_READ:
         begin
            st_next.state = HHDMA_WRITE;
            st_next.wcyc  = '0;
            st_next.addr  = st_reg.dst[st_reg.cur];
            st_next.we    = 1'b1;
         end
         HHDMA_WRITE:
         begin
            st_next.we   = 1'b1;
            st_next.wcyc = st_reg.wcyc + 1'b1;
            if (st_reg.wcyc == WR_LAST)
            begin
               st_next.we = 1'b0;
               st_next.src[st_reg.cur] = st_reg.src[st_reg.cur] + 1'b1;
               st_next.dst[st_reg.cur] = st_reg.dst[st_reg.cur] + 1'b1;
               st_next.left[st_reg.cur] = st_reg.left[st_reg.cur] - 1'b1;
               st_next.cnt  = st_reg.cnt - 1'b1;
               // window ends after the last byte
               if (st_reg.cnt == 9'h001)
               begin
                  st_next.halt  = 1'b0;
                  st_next.state = HHDMA_IDLE;
                  st_next.pend[st_reg.cur] = 1'b0;
                  st_next.done[st_reg.cur] = 1'b1;
               end
               else
               begin
                  st_next.state = HHDMA_READ;
                  st_next.addr  = st_reg.src[st_reg.cur] + 1'b1;
                  st_next.oe    = 1'b1;
               end
            end
         end
         default:
         begin
            st_next.state = HHDMA_IDLE;
         end
      endcase
      // Modem packets are fixed; general channels wait their idle time
      if (st_next.done != '0)
      begin
         st_next.idle[st_reg.cur] = idle_v[st_reg.cur];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign mem_drive     = st_reg.oe || st_reg.we;
   assign mem_addr      = mem_drive ? st_reg.addr : '0;
   assign mem_wdata     = st_reg.we ? fifo_out_data : '0;
   assign mem_oe        = st_reg.oe;
   assign mem_we        = st_reg.we;
   assign core_halt_req = st_reg.halt;
   assign ch_busy       = st_reg.pend;
   assign ch_done       = st_reg.done;
endmodule

/* File: common/hhdma_pkg.sv */
// Shared constants and types of the halt-handshake transfer engine
package hhdma_pkg;
   localparam int unsigned NUM_CH       = 4;
   localparam int unsigned ADDR_W       = 16;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned LEN_W        = 9;
   localparam int unsigned FIFO_DEPTH   = 32;
   // Channel indices, higher index wins arbitration
   localparam int unsigned CH_GEN2      = 0;
   localparam int unsigned CH_GEN1      = 1;
   localparam int unsigned CH_MODEM_TX  = 2;
   localparam int unsigned CH_MODEM_RX  = 3;
   // Modem channels move fixed packets of this many bytes
   localparam logic [LEN_W-1:0] MODEM_PKT_BYTES = 9'h010;
   // Byte timing in clock cycles
   localparam int unsigned READ_CYCLES  = 1;
   localparam int unsigned WRITE_CYCLES = 3;
   localparam int unsigned BYTE_CYCLES  = READ_CYCLES + WRITE_CYCLES;
   localparam logic [1:0] WR_LAST       = 2'(WRITE_CYCLES - 1);
   localparam logic [7:0] IDLE_RST      = 8'h00;

   typedef enum logic [1:0] {
      HHDMA_IDLE,
      HHDMA_WAIT_HALT,
      HHDMA_READ,
      HHDMA_WRITE
   } hhdma_state_t;
endpackage

/* File: verilog/hhdma_fifo.sv */
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module hhdma_fifo
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
)
(
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             arst_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned PW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [PW:0]                 count;
   } hhdma_fifo_st_t;

   hhdma_fifo_st_t st_reg;
   hhdma_fifo_st_t st_next;
   logic           push;
   logic           pop;

   assign in_ready  = (st_reg.count != (PW+1)'(DEPTH));
   assign out_valid = (st_reg.count != '0);
   assign out_data  = st_reg.mem[st_reg.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      st_next = st_reg;
      if (push)
      begin
         st_next.mem[st_reg.wr_ptr] = in_data;
         st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      end
      if (pop)
      begin
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
         st_next.count = st_reg.count + 1'b1;
      end
      else if (pop && !push)
      begin
         st_next.count = st_reg.count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end
endmodule

/* File: tb/hhdma_props.sv */
// Concurrent checks of the engine's halt handshake and byte timing
`timescale 1ns/1ps
module hhdma_props
   import hhdma_pkg::*;
(
   // Clock and reset
   input wire logic                         sys_clk,
   input wire logic                         arst_n,
   // Halt handshake and starts
   input wire logic                         core_halt_req,
   input wire logic                         core_halted,
   input wire logic                         modem_rx_start,
   input wire logic                         modem_tx_start,
   input wire logic                         gen1_start,
   input wire logic                         gen2_start,
   input wire logic [7:0]                   gen1_idle,
   input wire logic [7:0]                   gen2_idle,
   // Memory and status
   input wire logic [hhdma_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [hhdma_pkg::DATA_W-1:0] mem_wdata,
   input wire logic                         mem_oe,
   input wire logic                         mem_we,
   input wire logic                         mem_drive,
   input wire logic [hhdma_pkg::NUM_CH-1:0] ch_busy,
   input wire logic [hhdma_pkg::NUM_CH-1:0] ch_done
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic any_start;
   assign any_start = modem_rx_start | modem_tx_start |
                      gen1_start | gen2_start;
   property p_halt_first;
      mem_drive |-> core_halt_req && core_halted;
   endproperty
   a_halt_first: assert property (p_halt_first)
      else $error("memory cycle without halt handshake");
   property p_start_halt;
      any_start && ch_busy == '0 && !core_halt_req &&
      gen1_idle == 8'h00 && gen2_idle == 8'h00 |-> ##3 core_halt_req;
   endproperty
   a_start_halt: assert property (p_start_halt)
      else $error("halt request late after start");
   property p_ack_read;
      $rose(core_halted) && core_halt_req |-> ##[1:2] mem_oe;
   endproperty
   a_ack_read: assert property (p_ack_read)
      else $error("no read after acknowledge");
   property p_byte;
      mem_oe |-> !mem_we ##1 mem_we [*3] ##1 !mem_we;
   endproperty
   a_byte: assert property (p_byte)
      else $error("byte not one read and three writes");
   property p_drop_after_write;
      $fell(core_halt_req) |-> $past(mem_we);
   endproperty
   a_drop_after_write: assert property (p_drop_after_write)
      else $error("halt request dropped inside access");
   property p_window_end;
      $fell(mem_we) && !mem_oe |-> ##[0:1] !core_halt_req;
   endproperty
   a_window_end: assert property (p_window_end)
      else $error("halt request held after window");
   property p_done_once;
      |ch_done |-> $onehot(ch_done) ##1 ch_done == '0;
   endproperty
   a_done_once: assert property (p_done_once)
      else $error("done pulse malformed");
   property p_quiet;
      !core_halt_req |-> !mem_drive && mem_addr == '0 && mem_wdata == '0;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("memory signals driven while idle");
endmodule

bind hhdma_engine hhdma_props u_props (.sys_clk, .arst_n, .core_halt_req,
   .core_halted, .modem_rx_start, .modem_tx_start, .gen1_start, .gen2_start,
   .gen1_idle, .gen2_idle, .mem_addr, .mem_wdata, .mem_oe, .mem_we,
   .mem_drive, .ch_busy, .ch_done);

/* File: tb/hhdma_core_model.sv */
// Behavioural core with halt handshake and its data memory
`timescale 1ns/1ps
module hhdma_core_model
   import hhdma_pkg::*;
(
   // Clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         arst_n,
   // Halt handshake and delays
   input  wire logic                         core_halt_req,
   output logic                              core_halted,
   input  wire logic [4:0]                   ack_dly,
   input  wire logic [4:0]                   rel_dly,
   // Data memory
   input  wire logic [hhdma_pkg::ADDR_W-1:0] mem_addr,
   input  wire logic [hhdma_pkg::DATA_W-1:0] mem_wdata,
   output logic      [hhdma_pkg::DATA_W-1:0] mem_rdata,
   input  wire logic                         mem_oe,
   input  wire logic                         mem_we
);
   logic [7:0] mem [0:255];
   logic [7:0] last_rd;
   logic [4:0] cnt;
   initial
   begin
      last_rd = 8'h00;
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h5A;
   end
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         core_halted <= 1'b0;
         cnt         <= 5'h00;
      end
      else if (core_halt_req == core_halted)
         cnt <= 5'h00;
      else if (cnt + 5'h01 >= (core_halt_req ? ack_dly : rel_dly))
      begin
         core_halted <= core_halt_req;
         cnt         <= 5'h00;
      end
      else
         cnt <= cnt + 5'h01;
   end
   always @(posedge sys_clk)
   begin
      if (mem_we === 1'b1)
         mem[mem_addr[7:0]] <= mem_wdata;
      if (mem_oe === 1'b1)
         last_rd <= mem[mem_addr[7:0]];
   end
   // Released bus shows the inverse, so a stale byte cannot pass
   assign mem_rdata = mem_oe ? mem[mem_addr[7:0]] : ~last_rd;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench of the four-channel transfer engine
`timescale 1ns/1ps
module testbench;
   import hhdma_pkg::*;
   logic              sys_clk, arst_n, core_halt_req, core_halted;
   logic [4:0]        ack_dly, rel_dly;
   logic [3:0]        st, ch_busy, ch_done;
   logic [ADDR_W-1:0] rx_dst, tx_src, g1_src, g1_dst, g2_src, g2_dst, mem_addr;
   logic [LEN_W-1:0]  g1_ssz, g1_dsz, g2_ssz, g2_dsz;
   logic [7:0]        mem_wdata, mem_rdata, g1_idle, g2_idle;
   logic              mem_oe, mem_we, mem_drive, halt_d;
   logic [1:0]        done_q[$];
   int                n_errors = 0, checks = 0, drv_cnt = 0, n_rise = 0;
   int                cyc = 0, t_halt = 0;
   hhdma_engine u_dut (.sys_clk, .arst_n, .core_halt_req, .core_halted,
      .modem_rx_start(st[3]), .modem_rx_dst(rx_dst), .modem_rx_src(16'h0000),
      .modem_tx_start(st[2]), .modem_tx_src(tx_src), .modem_tx_dst(16'h00A0),
      .gen1_start(st[1]), .gen1_src(g1_src), .gen1_dst(g1_dst),
      .gen1_src_size(g1_ssz), .gen1_dst_size(g1_dsz), .gen1_idle(g1_idle),
      .gen2_start(st[0]), .gen2_src(g2_src), .gen2_dst(g2_dst),
      .gen2_src_size(g2_ssz), .gen2_dst_size(g2_dsz), .gen2_idle(g2_idle),
      .mem_addr, .mem_wdata, .mem_rdata, .mem_oe, .mem_we, .mem_drive,
      .ch_busy, .ch_done);
   hhdma_core_model u_core (.sys_clk, .arst_n, .core_halt_req, .core_halted,
      .ack_dly, .rel_dly, .mem_addr, .mem_wdata, .mem_rdata, .mem_oe, .mem_we);
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk)
   begin
      if (mem_drive === 1'b1) drv_cnt++;
      cyc++;
      if (core_halt_req === 1'b1 && halt_d !== 1'b1)
      begin
         n_rise++;
         if (n_rise == 1) t_halt = cyc;
      end
      halt_d = core_halt_req;
      for (int k = 3; k >= 0; k--)
         if (ch_done[k] === 1'b1) done_q.push_back(2'(k));
   end
   function automatic logic [7:0] fv(int a);
      return 8'(a) ^ 8'h5A;
   endfunction
   task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Pulse starts, then wait bounded until engine and core are idle
   task automatic go(logic [3:0] mask);
      int i;
      drv_cnt = 0;
      n_rise = 0;
      cyc = 0;
      t_halt = 0;
      done_q.delete();
      @(posedge sys_clk) st <= mask;
      @(posedge sys_clk) st <= 4'h0;
      repeat (2) @(posedge sys_clk);
      for (i = 0; i < 4000; i++)
      begin
         @(negedge sys_clk);
         if (ch_busy === 4'h0 && core_halted === 1'b0) break;
      end
      if (i >= 4000)
      begin
         chk("idle wait", 16'h0001, 16'h0000);
         report_and_stop;
      end
   endtask
   task automatic t_gen_copy;
      @(posedge sys_clk);
      ack_dly <= 5'd18;
      rel_dly <= 5'd9;
      g1_src <= 16'h0010;
      g1_dst <= 16'h0080;
      g1_ssz <= 9'h003;
      g1_dsz <= 9'h005;
      g1_idle <= 8'h30;
      go(4'h2);
      chk("window cycles", 16'(drv_cnt), 16'h000C);
      chk("done count", 16'(done_q.size()), 16'h0001);
      for (int i = 0; i < 5; i++)
         chk("gen byte", mem_rd(128 + i), fv(i < 3 ? 16 + i : 128 + i));
      // Restart at once: the request must wait out the idle gap
      @(posedge sys_clk);
      g1_dst <= 16'h00B0;
      go(4'h2);
      chk("idle gap", 16'(t_halt > 30), 16'h0001);
      chk("window cycles", 16'(drv_cnt), 16'h000C);
      chk("gen byte", mem_rd(176), fv(16));
      $display("Test general copy finished");
   endtask
   function automatic logic [7:0] mem_rd(int a);
      return u_core.mem[a];
   endfunction
   task automatic t_priority;
      @(posedge sys_clk);
      ack_dly <= 5'd1;
      rel_dly <= 5'd1;
      g1_idle <= 8'h00;
      rx_dst <= 16'h0040;
      tx_src <= 16'h0060;
      g1_dst <= 16'h0084;
      g1_ssz <= 9'h001;
      g2_ssz <= 9'h002;
      g2_dsz <= 9'h002;
      go(4'hF);
      for (int i = 0; i < 4; i++)
         chk("grant order", 16'(done_q[i]), 16'(3 - i));
      chk("window cycles", 16'(drv_cnt), 16'h008C);
      chk("halt requests", 16'(n_rise), 16'h0004);
      for (int i = 0; i < 16; i++)
      begin
         chk("rx byte", mem_rd(64 + i), fv(i));
         chk("tx byte", mem_rd(160 + i), fv(96 + i));
      end
      chk("gen1 byte", mem_rd(132), fv(16));
      chk("gen2 byte", mem_rd(145), fv(33));
      $display("Test priority finished");
   endtask
   initial
   begin
      arst_n = 1'b0;
      st = 4'h0;
      ack_dly = 5'd1;
      rel_dly = 5'd1;
      {rx_dst, tx_src, g1_src, g1_dst} = 64'h0040_0060_0010_0080;
      {g2_src, g2_dst} = 32'h0020_0090;
      {g1_idle, g2_idle} = 16'h0000;
      {g1_ssz, g1_dsz, g2_ssz, g2_dsz} = 36'h0_0000_0000;
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_gen_copy;
      t_priority;
      report_and_stop;
   end
endmodule
